// ---- rtl/pmw_pkg.sv ----
// package: constants and types for the motion wake-up alert block
package pmw_pkg;
  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 100;
  localparam int unsigned OSC_HZ          = 32_000;
  localparam int unsigned OSC_DIV         = CLK_HZ / OSC_HZ;
  localparam int unsigned CLEAR_LOW_US    = 160;
  localparam int unsigned CLEAR_LOW_CYC   = (CLEAR_LOW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HALF_SEC_MS     = 500;
  localparam int unsigned HALF_SEC_TICKS  = OSC_HZ * HALF_SEC_MS / 1000;
  localparam int unsigned SMPL_MIN_US     = 2000;
  localparam int unsigned SMPL_MAX_US     = 12500;
  localparam int unsigned SMPL_MIN_TICKS  = (SMPL_MIN_US * (OSC_HZ / 1000) + 999) / 1000;
  localparam int unsigned SMPL_MAX_TICKS  = SMPL_MAX_US * (OSC_HZ / 1000) / 1000;

  // ------------------------------------------------------------------
  // samples
  // ------------------------------------------------------------------
  localparam int unsigned SAMPLE_W        = 14;
  localparam logic [13:0] RANGE_LO        = 14'h01ff;
  localparam logic [13:0] RANGE_HI        = 14'h3e01;

  // ------------------------------------------------------------------
  // configuration register
  // ------------------------------------------------------------------
  localparam int unsigned CFG_W        = 25;
  localparam int unsigned CFG_THR_LSB  = 17;
  localparam int unsigned CFG_BLD_LSB  = 13;
  localparam int unsigned CFG_PLS_LSB  = 11;
  localparam int unsigned CFG_WIN_LSB  = 9;
  localparam int unsigned CFG_MODE_LSB = 7;
  localparam int unsigned CFG_SRC_LSB  = 5;
  localparam int unsigned CFG_CNT_BIT  = 0;
  localparam logic [24:0] CFG_RESET    = 25'h0000000;

  // ------------------------------------------------------------------
  // apb registers
  // ------------------------------------------------------------------
  localparam logic [7:0] REG_CFG     = 8'h00;
  localparam logic [7:0] REG_SAMPLE  = 8'h04;
  localparam logic [7:0] REG_IRQ_ST  = 8'h08;
  localparam logic [7:0] REG_IRQ_MSK = 8'h0c;
  localparam logic [7:0] REG_STATUS  = 8'h10;
  localparam int unsigned IRQ_ALERT  = 0;
  localparam int unsigned IRQ_CLEAR  = 1;
  localparam int unsigned IRQ_RANGE  = 2;
  localparam int unsigned IRQ_W      = 3;

  typedef enum logic [1:0] {
    PMW_FORCED, PMW_INTR, PMW_WAKE, PMW_RSVD
  } pmw_mode_t;

  typedef enum logic [1:0] {
    PMW_SRC_BPF, PMW_SRC_LPF, PMW_SRC_RSV, PMW_SRC_TEMP
  } pmw_src_t;

  typedef struct packed {
    logic [7:0] threshold;
    logic [3:0] blind;
    logic [1:0] pulses;
    logic [1:0] window;
    pmw_mode_t  mode;
    pmw_src_t   source;
    logic       no_sign_change;
  } pmw_cfg_t;

  typedef struct packed {
    logic        valid;
    logic [13:0] band_pass_output;
    logic [13:0] low_pass_output;
    logic [13:0] temp;
  } pmw_samples_t;
endpackage : pmw_pkg

// ---- rtl/pmw_alert.sv ----
// module: motion detection, wake-up alert and apb register file
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/100ps
module pmw_alert (
  // clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic                     pslverr,
  output logic [31:0]              prdata,
  // configuration loader
  input  wire logic                config_serial_input_valid,
  input  wire logic [24:0]         config_serial_input_word,
  // converter, one 14-bit result per strobe, channel in adc_chan
  input  wire logic                adc_valid,
  input  wire logic [1:0]          adc_chan,
  input  wire logic [13:0]         adc_data,
  output logic [1:0]               adc_mux_sel,
  // alert and data line
  input  wire logic                alert_data_line_in,
  output logic                     alert_data_line_out,
  output logic                     alert_data_line_oe,
  output logic                     stream_mode,
  output logic                     sample_slow,
  output logic                     irq
);
  // ----------------------------------------------------------------
  // synchroniser and oscillator tick
  // ----------------------------------------------------------------
  logic        line_meta_reg;
  logic        line_sync_reg;
  logic [8:0]  div_reg;
  logic        tick_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_meta_reg <= 1'b0;
      line_sync_reg <= 1'b0;
    end else begin
      line_meta_reg <= alert_data_line_in;
      line_sync_reg <= line_meta_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg  <= 9'h000;
      tick_reg <= 1'b0;
    end else if (div_reg == 9'(pmw_pkg::OSC_DIV - 1)) begin
      div_reg  <= 9'h000;
      tick_reg <= 1'b1;
    end else begin
      div_reg  <= div_reg + 9'h001;
      tick_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // configuration
  // ----------------------------------------------------------------
  logic [24:0]       cfg_reg;
  pmw_pkg::pmw_cfg_t cfg;

  // volatile, only the serial loader writes it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cfg_reg <= pmw_pkg::CFG_RESET;
    else if (config_serial_input_valid)
      cfg_reg <= config_serial_input_word;
  end

  always_comb begin
    cfg.threshold      = cfg_reg[pmw_pkg::CFG_THR_LSB +: 8];
    cfg.blind          = cfg_reg[pmw_pkg::CFG_BLD_LSB +: 4];
    cfg.pulses         = cfg_reg[pmw_pkg::CFG_PLS_LSB +: 2];
    cfg.window         = cfg_reg[pmw_pkg::CFG_WIN_LSB +: 2];
    cfg.mode           = pmw_pkg::pmw_mode_t'(cfg_reg[pmw_pkg::CFG_MODE_LSB +: 2]);
    cfg.source         = pmw_pkg::pmw_src_t'(cfg_reg[pmw_pkg::CFG_SRC_LSB +: 2]);
    cfg.no_sign_change = cfg_reg[pmw_pkg::CFG_CNT_BIT];
  end

  logic wake;
  assign wake = (cfg.mode == pmw_pkg::PMW_WAKE);

  // ----------------------------------------------------------------
  // converter multiplexing and samples
  // ----------------------------------------------------------------
  pmw_pkg::pmw_samples_t smp_reg;
  logic                  out_range_reg;
  logic                  bpf_new_reg;
  logic [15:0]           gap_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      adc_mux_sel <= 2'h0;
    else if (adc_valid)
      adc_mux_sel <= (adc_mux_sel == 2'h2) ? 2'h0 : adc_mux_sel + 2'h1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smp_reg       <= '0;
      out_range_reg <= 1'b0;
      bpf_new_reg   <= 1'b0;
    end else begin
      bpf_new_reg <= adc_valid && (adc_chan == 2'h0);
      if (adc_valid) begin
        smp_reg.valid <= 1'b1;
        case (adc_chan)
          2'h0: smp_reg.band_pass_output  <= adc_data;
          2'h1: begin
            smp_reg.low_pass_output   <= adc_data;
            out_range_reg <= (adc_data < pmw_pkg::RANGE_LO) || (adc_data > pmw_pkg::RANGE_HI);
          end
          2'h2: smp_reg.temp <= adc_data;
          default: smp_reg.valid <= smp_reg.valid;
        endcase
      end
    end
  end

  // interval since last band-pass sample, in oscillator ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_reg     <= 16'h0000;
      sample_slow <= 1'b0;
    end else begin
      if (bpf_new_reg)
        gap_reg <= 16'h0000;
      else if (tick_reg && gap_reg != 16'hffff)
        gap_reg <= gap_reg + 16'h0001;
      sample_slow <= (cfg.mode == pmw_pkg::PMW_INTR) &&
                     (gap_reg > 16'(pmw_pkg::SMPL_MAX_TICKS));
    end
  end

  // ----------------------------------------------------------------
  // pulse detection
  // ----------------------------------------------------------------
  function automatic logic [13:0] mag14(input logic [13:0] v);
    return v[13] ? 14'(~v + 14'h0001) : v;
  endfunction

  logic [13:0] bpf_mag;
  logic        over;
  logic        last_sign_reg;
  logic        sign_ok;
  assign bpf_mag = mag14(smp_reg.band_pass_output);
  assign over    = bpf_mag > {6'h00, cfg.threshold};
  assign sign_ok = cfg.no_sign_change || (smp_reg.band_pass_output[13] != last_sign_reg);

  // ----------------------------------------------------------------
  // moving window, alert latch, clear and blind time
  // ----------------------------------------------------------------
  typedef enum logic [1:0] { PMW_IDLE, PMW_ARMED, PMW_ALERT, PMW_BLIND } pmw_state_t;
  pmw_state_t  state_reg;
  logic [2:0]  pcount_reg;
  logic [17:0] wticks_reg;
  logic [18:0] bticks_reg;
  logic [11:0] low_cnt_reg;
  logic        cleared;
  logic        pulse;
  logic [17:0] win_len;
  logic [18:0] blind_len;

  assign pulse     = bpf_new_reg && over && sign_ok;
  assign cleared   = (low_cnt_reg == 12'(pmw_pkg::CLEAR_LOW_CYC));
  assign win_len   = 18'(({16'h0000, cfg.window} + 18'h1) * 18'(4 * pmw_pkg::HALF_SEC_TICKS));
  assign blind_len = 19'(({15'h0000, cfg.blind} + 19'h1) * 19'(pmw_pkg::HALF_SEC_TICKS));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      low_cnt_reg <= 12'h000;
    else if (line_sync_reg || state_reg != PMW_ALERT)
      low_cnt_reg <= 12'h000;
    else if (!cleared)
      low_cnt_reg <= low_cnt_reg + 12'h001;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      last_sign_reg <= 1'b0;
    else if (pulse && wake && state_reg == PMW_ARMED)
      last_sign_reg <= smp_reg.band_pass_output[13];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg  <= PMW_IDLE;
      pcount_reg <= 3'h0;
      wticks_reg <= 18'h00000;
      bticks_reg <= 19'h00000;
    end else if (!wake) begin
      state_reg  <= PMW_IDLE;
      pcount_reg <= 3'h0;
    end else begin
      case (state_reg)
        PMW_IDLE: state_reg <= PMW_ARMED;
        PMW_ARMED: begin
          if (tick_reg && pcount_reg != 3'h0) begin
            if (wticks_reg >= win_len) begin
              pcount_reg <= 3'h0;
              wticks_reg <= 18'h00000;
            end else begin
              wticks_reg <= wticks_reg + 18'h00001;
            end
          end
          if (pulse) begin
            if (pcount_reg == 3'h0)
              wticks_reg <= 18'h00000;
            pcount_reg <= pcount_reg + 3'h1;
            if (pcount_reg >= {1'b0, cfg.pulses})
              state_reg <= PMW_ALERT;
          end
        end
        PMW_ALERT: begin
          if (cleared) begin
            state_reg  <= PMW_BLIND;
            bticks_reg <= 19'h00000;
            pcount_reg <= 3'h0;
          end
        end
        PMW_BLIND: begin
          if (tick_reg) begin
            if (bticks_reg >= blind_len)
              state_reg <= PMW_ARMED;
            else
              bticks_reg <= bticks_reg + 19'h00001;
          end
        end
        default: state_reg <= PMW_IDLE;
      endcase
    end
  end

  // line driver: high when alerting, released otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alert_data_line_out <= 1'b0;
      alert_data_line_oe  <= 1'b0;
      stream_mode         <= 1'b0;
    end else begin
      stream_mode         <= !wake && cfg.mode != pmw_pkg::PMW_RSVD;
      alert_data_line_out <= (state_reg == PMW_ALERT) && wake;
      alert_data_line_oe  <= (state_reg == PMW_ALERT) && wake;
    end
  end

  // ----------------------------------------------------------------
  // interrupts and apb
  // ----------------------------------------------------------------
  logic [2:0]  irq_st_reg;
  logic [2:0]  irq_msk_reg;
  logic [2:0]  ev;
  logic        wr;
  logic        rd;
  logic        prev_alert_reg;
  logic        prev_range_reg;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign ev = {out_range_reg && !prev_range_reg,
               (state_reg == PMW_BLIND) && prev_alert_reg,
               (state_reg == PMW_ALERT) && !prev_alert_reg};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_reg     <= 3'h0;
      irq_msk_reg    <= 3'h0;
      prev_alert_reg <= 1'b0;
      prev_range_reg <= 1'b0;
      irq            <= 1'b0;
    end else begin
      prev_alert_reg <= (state_reg == PMW_ALERT);
      prev_range_reg <= out_range_reg;
      if (wr && paddr == pmw_pkg::REG_IRQ_ST)
        irq_st_reg <= (irq_st_reg & ~pwdata[2:0]) | ev;
      else
        irq_st_reg <= irq_st_reg | ev;
      if (wr && paddr == pmw_pkg::REG_IRQ_MSK)
        irq_msk_reg <= pwdata[2:0];
      irq <= |(irq_st_reg & irq_msk_reg);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        pslverr <= !(paddr inside {pmw_pkg::REG_CFG, pmw_pkg::REG_SAMPLE, pmw_pkg::REG_IRQ_ST,
                                   pmw_pkg::REG_IRQ_MSK, pmw_pkg::REG_STATUS}) ||
                   (pwrite && (paddr == pmw_pkg::REG_CFG || paddr == pmw_pkg::REG_SAMPLE ||
                               paddr == pmw_pkg::REG_STATUS));
      end
      if (rd) begin
        case (paddr)
          pmw_pkg::REG_CFG:     prdata <= {7'h00, cfg_reg};
          pmw_pkg::REG_SAMPLE:  prdata <= {2'h0, (cfg.source == pmw_pkg::PMW_SRC_LPF) ?
                                           smp_reg.low_pass_output : (cfg.source == pmw_pkg::PMW_SRC_TEMP) ?
                                           smp_reg.temp : smp_reg.band_pass_output, !out_range_reg, 15'h0000};
          pmw_pkg::REG_IRQ_ST:  prdata <= {29'h0, irq_st_reg};
          pmw_pkg::REG_IRQ_MSK: prdata <= {29'h0, irq_msk_reg};
          pmw_pkg::REG_STATUS:  prdata <= {25'h0, pcount_reg, sample_slow, wake, state_reg};
          default:              prdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // pmw_alert

// ---- sim/pmw_alert_props.sv ----
// checker: port-level properties of the motion wake-up alert block
`timescale 1ns/100ps
module pmw_alert_props (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb handshake
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  // configuration and converter
  input wire logic        config_serial_input_valid,
  input wire logic [24:0] config_serial_input_word,
  input wire logic        adc_valid,
  input wire logic [1:0]  adc_mux_sel,
  // alert line
  input wire logic        alert_data_line_in,
  input wire logic        alert_data_line_out,
  input wire logic        alert_data_line_oe,
  input wire logic        stream_mode
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [1:0]  mode_reg;
  logic [11:0] low_reg;
  logic        cleared_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) mode_reg <= 2'h0;
    else if (config_serial_input_valid) mode_reg <= config_serial_input_word[8:7];
  end
  // consecutive low cycles seen on the wire
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) low_reg <= 12'h0;
    else if (alert_data_line_in) low_reg <= 12'h0;
    else if (low_reg != 12'hfff) low_reg <= low_reg + 12'h1;
  end
  // blind time is far longer than any run, so any clear means blind to the end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cleared_reg <= 1'b0;
    else if ($fell(alert_data_line_out)) cleared_reg <= 1'b1;
  end
  sequence s_setup; psel && !penable; endsequence
  sequence s_quiet; !config_serial_input_valid [*3]; endsequence
  property p_ready; s_setup |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready in first access cycle");
  property p_stream; s_quiet |-> stream_mode == (mode_reg < 2'h2); endproperty
  a_stream: assert property (p_stream) else $error("line use does not follow mode");
  property p_hold; alert_data_line_out && alert_data_line_in |=> alert_data_line_out; endproperty
  a_hold: assert property (p_hold) else $error("alert dropped while line high");
  property p_nonwake;
    mode_reg != 2'h2 && $stable(mode_reg) && !alert_data_line_out |=> !alert_data_line_out;
  endproperty
  a_nonwake: assert property (p_nonwake) else $error("alert outside wake mode");
  property p_oe; alert_data_line_oe |-> alert_data_line_out; endproperty
  a_oe: assert property (p_oe) else $error("line driven low by device");
  property p_rise;
    $rose(alert_data_line_out) |-> $past(adc_valid, 2) || $past(adc_valid, 3) || $past(adc_valid, 4);
  endproperty
  a_rise: assert property (p_rise) else $error("alert rose without a sample");
  property p_clr_min; $fell(alert_data_line_out) |-> low_reg >= 12'(pmw_pkg::CLEAR_LOW_CYC); endproperty
  a_clr_min: assert property (p_clr_min) else $error("alert cleared by short low");
  property p_clr_max; low_reg == 12'(pmw_pkg::CLEAR_LOW_CYC + 40) |-> !alert_data_line_out; endproperty
  a_clr_max: assert property (p_clr_max) else $error("alert not cleared by long low");
  property p_blind; cleared_reg |-> !$rose(alert_data_line_out); endproperty
  a_blind: assert property (p_blind) else $error("alert during blind time");
  property p_mux;
    adc_valid |=> adc_mux_sel == (($past(adc_mux_sel) == 2'h2) ? 2'h0 : $past(adc_mux_sel) + 2'h1);
  endproperty
  a_mux: assert property (p_mux) else $error("converter mux not rotating");
endmodule // pmw_alert_props

bind pmw_alert pmw_alert_props u_props (
  .pclk, .presetn, .psel, .penable, .pready, .config_serial_input_valid,
  .config_serial_input_word, .adc_valid, .adc_mux_sel, .alert_data_line_in,
  .alert_data_line_out, .alert_data_line_oe, .stream_mode
);

// ---- sim/pmw_host_model.sv ----
// partner: host microcontroller side of the one-wire alert line
`timescale 1ns/100ps
module pmw_host_model (
  // clock
  input  wire logic        pclk,
  // device side of the wire
  input  wire logic        dev_level,
  input  wire logic        dev_drive,
  // clear request
  input  wire logic        go,
  input  wire logic [15:0] len,
  // resolved wire
  output logic             line,
  output logic             busy
);
  logic [15:0] cnt_reg;
  logic        flt_reg;
  initial begin
    cnt_reg = 16'h0;
    flt_reg = 1'b0;
  end
  // no pull resistor: a released wire shows the inverse of its last driven level
  always @(posedge pclk) begin
    if (busy) flt_reg <= 1'b1;
    else if (dev_drive) flt_reg <= ~dev_level;
  end
  // short lengths model a careless host that lets go too soon
  always @(posedge pclk) begin
    if (go) cnt_reg <= len;
    else if (cnt_reg != 16'h0) cnt_reg <= cnt_reg - 16'h1;
  end
  assign busy = (cnt_reg != 16'h0);
  assign line = busy ? 1'b0 : (dev_drive ? dev_level : flt_reg);
endmodule // pmw_host_model

// ---- sim/pyro_motion_wakeup_alert_tb_top.sv ----
// bench: self-checking top for the motion wake-up alert block
`timescale 1ns/100ps
module pyro_motion_wakeup_alert_tb_top;
  localparam logic [7:0] A_ST = pmw_pkg::REG_IRQ_ST;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        cfg_v, adc_valid, line, out, oe, stream_mode, irq, go, busy, rd_err, slow;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_data;
  logic [24:0] cw;
  logic [13:0] adc_data;
  logic [1:0]  adc_chan, mux;
  logic [15:0] len;
  logic [2:0]  st;
  integer      seed, error_cnt, n_compared, thr, npl, cnt;
  bit          wake, cm, blind, lsg, aexp;

  pmw_alert dut_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
    .config_serial_input_valid(cfg_v), .config_serial_input_word(cw),
    .adc_valid, .adc_chan, .adc_data, .adc_mux_sel(mux),
    .alert_data_line_in(line), .alert_data_line_out(out), .alert_data_line_oe(oe),
    .stream_mode, .sample_slow(slow), .irq
  );
  pmw_host_model host_u (.pclk, .dev_level(out), .dev_drive(oe), .go, .len, .line, .busy);

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic finish_test;
    if (error_cnt == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic hang;
    error_cnt++;
    finish_test();
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    if (pready !== 1'b1) hang();
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // temperature chosen for readout; detection must still use band-pass
  task automatic cfg(input int t, input int p, input int md, input int c);
    @(posedge pclk);
    cw <= 25'((t << pmw_pkg::CFG_THR_LSB) | (p << pmw_pkg::CFG_PLS_LSB)
         | (md << pmw_pkg::CFG_MODE_LSB) | (c << pmw_pkg::CFG_CNT_BIT)) | 25'h70;
    cfg_v <= 1'b1;
    @(posedge pclk);
    cfg_v <= 1'b0;
    thr = t;
    npl = p;
    wake = (md == 2);
    cm = c[0];
  endtask
  function automatic logic [13:0] low_pass_output();
    return 14'h0200 + 14'($random(seed) & 32'h1fff);
  endfunction
  task automatic smp(input logic [13:0] b, input logic [13:0] l);
    logic [13:0] v [3];
    int m;
    v[0] = b;
    v[1] = l;
    v[2] = 14'($random(seed));
    m = $signed(b);
    for (int c = 0; c < 3; c++) begin
      @(posedge pclk);
      adc_valid <= 1'b1;
      adc_chan <= 2'(c);
      adc_data <= v[c];
      @(posedge pclk);
      adc_valid <= 1'b0;
      repeat (3) @(posedge pclk);
    end
    if (l < 14'h01ff || l > 14'h3e01) st[2] = 1'b1;
    if (wake && !blind && !aexp && (m > thr || -m > thr) && (cm || b[13] != lsg)) begin
      lsg = b[13];
      cnt++;
      aexp = (cnt == npl + 1);
      st[0] = aexp;
    end
    chk(32'(out), 32'(aexp));
  endtask
  task automatic host(input int n);
    int i;
    @(posedge pclk);
    go <= 1'b1;
    len <= 16'(n);
    @(posedge pclk);
    go <= 1'b0;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (busy !== 1'b0 && i < n + 8);
    if (busy !== 1'b0) hang();
    if (aexp && n > pmw_pkg::CLEAR_LOW_CYC + 8) begin
      aexp = 1'b0;
      blind = 1'b1;
      st[1] = 1'b1;
    end
    repeat (8) @(posedge pclk);
  endtask
  task automatic do_reset;
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    aexp = 1'b0;
    blind = 1'b0;
    wake = 1'b0;
    lsg = 1'b0;
    cnt = 0;
    st = 3'h0;
  endtask

  initial begin
    logic [13:0] pat [6];
    logic [13:0] rng [3];
    int          md [4];
    pat = '{14'h0040, 14'h3fc0, 14'h0064, 14'h3f9c, 14'h3f9c, 14'h0064};
    rng = '{14'h01ff, 14'h3e01, 14'h01fe};
    md = '{0, 1, 3, 2};
    seed = 23584;
    error_cnt = 0;
    n_compared = 0;
    {presetn, psel, penable, pwrite, cfg_v, adc_valid, go} = 7'h0;
    {paddr, pwdata, cw, adc_data, adc_chan, len} = 97'h0;
    do_reset;
    apb(1'b0, pmw_pkg::REG_CFG, 32'h0);
    chk(rd_data, 32'h0);
    apb(1'b1, pmw_pkg::REG_CFG, 32'h1ffffff);
    chk(32'(rd_err), 32'h1);
    apb(1'b0, 8'h14, 32'h0);
    chk(32'(rd_err), 32'h1);
    cfg(64, 1, 2, 0);
    apb(1'b0, pmw_pkg::REG_CFG, 32'h0);
    chk(rd_data, 32'(cw));
    chk(32'(stream_mode), 32'h0);
    repeat (4) smp(14'($random(seed) % 64), low_pass_output());
    foreach (pat[i]) smp(pat[i], low_pass_output());
    chk(32'(irq), 32'h0);
    apb(1'b0, A_ST, 32'h0);
    chk(rd_data, 32'(st));
    apb(1'b1, pmw_pkg::REG_IRQ_MSK, 32'h1);
    apb(1'b0, pmw_pkg::REG_IRQ_MSK, 32'h0);
    chk(rd_data, 32'h1);
    chk(32'(irq), 32'h1);
    apb(1'b1, A_ST, 32'h1);
    st[0] = 1'b0;
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0);
    foreach (rng[i]) begin
      smp(14'h0, rng[i]);
      apb(1'b0, A_ST, 32'h0);
      chk(rd_data, 32'(st));
    end
    repeat (300) @(posedge pclk);
    chk(32'(out), 32'h1);
    host(1500);
    chk(32'(out), 32'h1);
    host(1650);
    chk(32'(out), 32'h0);
    apb(1'b0, A_ST, 32'h0);
    chk(rd_data, 32'(st));
    foreach (pat[i]) smp(pat[i], low_pass_output());
    do_reset;
    foreach (md[i]) begin
      cfg(100, 0, md[i], 1);
      repeat (3) @(posedge pclk);
      chk(32'(stream_mode), 32'(md[i] < 2));
      chk(32'(slow), 32'h0);
      smp(14'h3f00, low_pass_output());
    end
    finish_test();
  end
endmodule // pyro_motion_wakeup_alert_tb_top
